// ==== core/status_alarm_latch_logger.sv ====
// Status registers, operator alarm latch and status change logger
//
// Overview of operation
// - Three sixteen-bit status registers: calibration, operational, other alarms.
// - Condition bits follow their source and clear once the condition ends.
// - Event bits stay set until the five-minute boundary after being logged.
// - Operator copy of register one keeps raised alarms until manual reset.
// - Manual reset clears only alarms whose cause has gone.
// - A lock input makes manual reset requests be ignored.
// - Registers shown as three four-character hex values, register one first.
// - A status bit that differs from its last logged value, set or clear, gives one time-stamped entry.
// - Each entry names the register as 1, 2 or 3.
// - Each entry names the bit as one hex digit, 0 to 9 then A up.
// - Nature code: event 0200, condition start 0400, condition end 0800.
`timescale 1ns/100ps
module status_alarm_latch_logger #(
   parameter int unsigned CyclesPerSec = status_alarm_pkg::CLK_HZ,
   parameter int unsigned SecPerBoundary = status_alarm_pkg::BOUNDARY_SEC,
   parameter logic [15:0] EventMask1 = status_alarm_pkg::EVENT_MASK1,
   parameter logic [15:0] EventMask2 = status_alarm_pkg::EVENT_MASK2,
   parameter logic [15:0] EventMask3 = status_alarm_pkg::EVENT_MASK3
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [15:0] source1,
   input wire logic [15:0] source2,
   input wire logic [15:0] source3,
   input wire logic resetRequest,
   input wire logic resetLock,
   input wire logic logReady,
   output logic [15:0] statusReg1,
   output logic [15:0] statusReg2,
   output logic [15:0] statusReg3,
   output logic [15:0] latchedAlarms,
   output logic [95:0] statusSummaryString,
   output logic logValid,
   output logic [1:0] logRegister,
   output logic [3:0] logBitDigit,
   output logic [15:0] logNature,
   output logic [31:0] logStamp
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [7:0] hexChar(input logic [3:0] n);
      if (n > status_alarm_pkg::DIGIT_LIMIT) begin
         return status_alarm_pkg::ASCII_LETTER_BASE + {4'h0, n};
      end else begin
         return status_alarm_pkg::ASCII_ZERO + {4'h0, n};
      end
   endfunction

   // Lowest changed bit wins; the rest follow on later cycles
   function automatic logic [5:0] firstSet(input logic [47:0] v);
      logic [5:0] idx;
      idx = 6'h00;
      for (int i = 47; i >= 0; i--) begin
         if (v[i]) begin
            idx = 6'(i);
         end
      end
      return idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Timebase: one-second enable, boundary enable and time stamp

   logic [31:0] secCnt_q;
   logic secTick_q;
   logic [31:0] bndCnt_q;
   logic boundaryTick_q;
   logic [31:0] stamp_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         secCnt_q <= 32'h0000_0000;
         secTick_q <= 1'b0;
      end else if (secCnt_q == 32'(CyclesPerSec - 1)) begin
         secCnt_q <= 32'h0000_0000;
         secTick_q <= 1'b1;
      end else begin
         secCnt_q <= secCnt_q + 32'h0000_0001;
         secTick_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bndCnt_q <= 32'h0000_0000;
         boundaryTick_q <= 1'b0;
      end else if (secTick_q && bndCnt_q == 32'(SecPerBoundary - 1)) begin
         bndCnt_q <= 32'h0000_0000;
         boundaryTick_q <= 1'b1;
      end else begin
         if (secTick_q) begin
            bndCnt_q <= bndCnt_q + 32'h0000_0001;
         end
         boundaryTick_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stamp_q <= status_alarm_pkg::STAMP_RESET;
      end else if (secTick_q) begin
         stamp_q <= stamp_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status registers

   logic [47:0] srcVec;
   logic [47:0] evMask;
   logic [47:0] statusVec;
   logic [47:0] statusD;
   logic [47:0] loggedVec;

   assign srcVec = {source3, source2, source1};
   assign evMask = {EventMask3, EventMask2, EventMask1};
   assign statusVec = {statusReg3, statusReg2, statusReg1};

   always_comb begin
      for (int i = 0; i < 48; i++) begin
         if (evMask[i]) begin
            // A new event pulse wins over the boundary clear
            statusD[i] = srcVec[i]
               | (statusVec[i] & ~(boundaryTick_q & loggedVec[i]));
         end else begin
            statusD[i] = srcVec[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         statusReg1 <= status_alarm_pkg::STATUS_RESET;
         statusReg2 <= status_alarm_pkg::STATUS_RESET;
         statusReg3 <= status_alarm_pkg::STATUS_RESET;
      end else begin
         statusReg1 <= statusD[15:0];
         statusReg2 <= statusD[31:16];
         statusReg3 <= statusD[47:32];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operator latch of register one with protected manual reset

   logic reqMeta_q;
   logic reqSync_q;
   logic reqLast_q;
   logic lockMeta_q;
   logic lockSync_q;
   logic resetAccept;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reqMeta_q <= 1'b0;
         reqSync_q <= 1'b0;
         reqLast_q <= 1'b0;
         lockMeta_q <= 1'b0;
         lockSync_q <= 1'b0;
      end else begin
         reqMeta_q <= resetRequest;
         reqSync_q <= reqMeta_q;
         reqLast_q <= reqSync_q;
         lockMeta_q <= resetLock;
         lockSync_q <= lockMeta_q;
      end
   end

   assign resetAccept = reqSync_q & ~reqLast_q & ~lockSync_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         latchedAlarms <= status_alarm_pkg::STATUS_RESET;
      end else if (resetAccept) begin
         latchedAlarms <= statusVec[15:0];
      end else begin
         latchedAlarms <= latchedAlarms | statusVec[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hex presentation, register one first, top nibble first

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         statusSummaryString <= {12{status_alarm_pkg::ASCII_ZERO}};
      end else begin
         for (int k = 0; k < 12; k++) begin
            statusSummaryString[95 - 8 * k -: 8] <=
               hexChar(statusVec[(k / 4) * 16 + (3 - k % 4) * 4 +: 4]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status change log

   logic [47:0] logged_q;
   logic [47:0] diffVec;
   logic [5:0] scanIdx;
   logic found;
   logic loadOk;

   assign loggedVec = logged_q;
   assign diffVec = statusVec ^ logged_q;
   assign found = |diffVec;
   assign scanIdx = firstSet(diffVec);
   assign loadOk = ~logValid | logReady;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         logged_q <= 48'h0000_0000_0000;
      end else if (loadOk && found) begin
         logged_q[scanIdx] <= statusVec[scanIdx];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         logValid <= 1'b0;
         logRegister <= 2'h0;
         logBitDigit <= 4'h0;
         logNature <= 16'h0000;
         logStamp <= status_alarm_pkg::STAMP_RESET;
      end else if (loadOk && found) begin
         logValid <= 1'b1;
         logRegister <= scanIdx[5:4] + 2'h1;
         logBitDigit <= scanIdx[3:0];
         logStamp <= stamp_q;
         if (evMask[scanIdx]) begin
            logNature <= status_alarm_pkg::NATURE_EVENT;
         end else if (statusVec[scanIdx]) begin
            logNature <= status_alarm_pkg::NATURE_COND_ON;
         end else begin
            logNature <= status_alarm_pkg::NATURE_COND_OFF;
         end
      end else if (logReady) begin
         logValid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   sequence sLoad;
      loadOk && found;
   endsequence

   sequence sStall;
      logValid && !logReady;
   endsequence

   a_cond_follow: assert property (
      ##1 ((statusVec & ~evMask) == ($past(srcVec) & ~evMask)))
      else $error("condition bit does not follow its source");

   a_event_hold: assert property (
      !boundaryTick_q |=> (($past(statusVec) & evMask & ~statusVec) == 48'h0))
      else $error("event bit cleared away from a boundary");

   a_event_clear: assert property (
      boundaryTick_q |=>
         ((statusVec & evMask & $past(loggedVec) & ~$past(srcVec)) == 48'h0))
      else $error("logged event bit survived the boundary");

   a_latch_keep: assert property (
      !resetAccept |=> (($past(latchedAlarms) & ~latchedAlarms) == 16'h0))
      else $error("latched alarm lost without a reset");

   a_reset_cause: assert property (
      resetAccept |=> latchedAlarms == $past(statusVec[15:0]))
      else $error("manual reset did not keep active causes only");

   a_lock_block: assert property (
      lockSync_q && !srst |=> ($past(latchedAlarms) & ~latchedAlarms) == 16'h0)
      else $error("locked reset cleared an alarm");

   a_hex_first: assert property (
      ##1 statusSummaryString[95:88] == hexChar($past(statusVec[15:12])))
      else $error("first character not top nibble of register one");

   a_hex_last: assert property (
      ##1 statusSummaryString[7:0] == hexChar($past(statusVec[35:32])))
      else $error("last character not bottom nibble of register three");

   a_log_record: assert property (
      sLoad |=> logValid && loggedVec[$past(scanIdx)] == $past(statusVec[scanIdx]))
      else $error("change not recorded in an entry");

   a_log_reg: assert property (
      sLoad |=> logRegister != 2'h0 && logRegister - 2'h1 == $past(scanIdx[5:4]))
      else $error("register code wrong");

   a_log_digit: assert property (
      sLoad |=> logBitDigit == $past(scanIdx[3:0]))
      else $error("bit digit wrong");

   a_log_nature: assert property (
      sLoad |=> (logNature == status_alarm_pkg::NATURE_EVENT) == $past(evMask[scanIdx]))
      else $error("nature code does not match bit class");

   a_no_spurious: assert property (
      $rose(logValid) |-> $past(found))
      else $error("entry without a bit change");

   a_entry_hold: assert property (
      sStall |=> logValid && $stable(logRegister) && $stable(logBitDigit))
      else $error("entry changed while stalled");

endmodule

// ==== core/status_alarm_pkg.sv ====
// Constants shared by the status latch and log block
package status_alarm_pkg;
   localparam int unsigned REG_BITS = 16;
   localparam int unsigned REG_COUNT = 3;
   localparam int unsigned ALL_BITS = REG_BITS * REG_COUNT;
   // System clock rate and the logging boundary period
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned BOUNDARY_MIN = 5;
   localparam int unsigned BOUNDARY_SEC = BOUNDARY_MIN * 60;
   // Log entry nature codes
   localparam logic [15:0] NATURE_EVENT = 16'h0200;
   localparam logic [15:0] NATURE_COND_ON = 16'h0400;
   localparam logic [15:0] NATURE_COND_OFF = 16'h0800;
   // Bits classified as events; all other bits are conditions
   localparam logic [15:0] EVENT_MASK1 = 16'hf840;
   localparam logic [15:0] EVENT_MASK2 = 16'h3000;
   localparam logic [15:0] EVENT_MASK3 = 16'h0000;
   // Reset values
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [31:0] STAMP_RESET = 32'h0000_0000;
   // ASCII bases for hex characters
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_LETTER_BASE = 8'h37;
   localparam logic [3:0] DIGIT_LIMIT = 4'h9;
endpackage

// ==== testbench/log_reader_model.sv ====
// Log readout partner: takes status log entries with random stalls
`timescale 1ns/100ps
module log_reader_model (
   input wire logic sys_clk,
   input wire logic srst,
   output logic logReady
);
   // Stall about a third of the cycles so held entries are exercised
   always @(negedge sys_clk) begin
      logReady <= !srst && ($urandom % 3 != 0);
   end
endmodule

// ==== testbench/test_status_alarm_latch_logger.sv ====
// Self-checking bench for the status latch and log block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_status_alarm_latch_logger;
   logic sys_clk, srst, resetRequest, resetLock, logReady, logValid;
   logic [15:0] source1, source2, source3, statusReg1, statusReg2, statusReg3, latchedAlarms;
   logic [95:0] statusSummaryString;
   logic [1:0] logRegister;
   logic [3:0] logBitDigit;
   logic [15:0] logNature;
   logic [31:0] logStamp;
   logic [21:0] expQ[$];
   logic [21:0] got;
   localparam int CPS = 4;
   int cyc = 0;
   logic [31:0] lastStamp = 32'h0000_0000;
   int n_errors = 0;
   int checks_done = 0;

   status_alarm_latch_logger #(.CyclesPerSec(CPS), .SecPerBoundary(3)) dut (
      .sys_clk(sys_clk), .srst(srst), .source1(source1), .source2(source2),
      .source3(source3), .resetRequest(resetRequest), .resetLock(resetLock),
      .logReady(logReady), .statusReg1(statusReg1), .statusReg2(statusReg2),
      .statusReg3(statusReg3), .latchedAlarms(latchedAlarms),
      .statusSummaryString(statusSummaryString), .logValid(logValid),
      .logRegister(logRegister), .logBitDigit(logBitDigit), .logNature(logNature),
      .logStamp(logStamp));
   log_reader_model reader (.sys_clk(sys_clk), .srst(srst), .logReady(logReady));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic drain();
      for (int k = 0; k < 400 && (expQ.size() != 0 || logValid !== 1'b0); k++)
         @(negedge sys_clk);
      `CHK("log backlog", 0, expQ.size())
   endtask

   // Drive condition sources, note one entry per changed bit, then check the view
   task automatic setSrc(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      logic [47:0] o;
      logic [47:0] n;
      logic [95:0] s;
      o = {source3, source2, source1};
      n = {c, b, a};
      for (int i = 0; i < 48; i++)
         if (o[i] !== n[i])
            expQ.push_back({2'(i / 16 + 1), 4'(i % 16), n[i] ? 16'h0400 : 16'h0800});
      @(negedge sys_clk);
      source1 = a;
      source2 = b;
      source3 = c;
      drain();
      `CHK("status", {a, b, c}, {statusReg1, statusReg2, statusReg3})
      s = {hexc(a[15:12]), hexc(a[11:8]), hexc(a[7:4]), hexc(a[3:0]),
           hexc(b[15:12]), hexc(b[11:8]), hexc(b[7:4]), hexc(b[3:0]),
           hexc(c[15:12]), hexc(c[11:8]), hexc(c[7:4]), hexc(c[3:0])};
      `CHK("summary string", s, statusSummaryString)
   endtask

   task automatic pulseReset();
      repeat (4) @(negedge sys_clk);
      resetRequest = 1'b1;
      repeat (4) @(negedge sys_clk);
      resetRequest = 1'b0;
      repeat (6) @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Each accepted entry is matched against the oldest note
   always @(posedge sys_clk) begin
      if (srst === 1'b0 && logValid === 1'b1 && logReady === 1'b1) begin
         if (expQ.size() == 0) begin
            `CHK("unexpected entry", 1'b0, 1'b1)
         end else begin
            got = expQ.pop_front();
            `CHK("log entry", got, {logRegister, logBitDigit, logNature})
            // Stamp counts seconds since reset: never backwards, never ahead of time
            `CHK("log stamp", 1'b1, logStamp >= lastStamp && logStamp <= 32'(cyc / CPS))
            lastStamp = logStamp;
         end
      end
      cyc = (srst === 1'b1) ? 0 : cyc + 1;
   end

   initial begin
      #(25 * 20000);
      n_errors++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'he0f6c188));
      srst = 1'b1;
      source1 = 16'h0000;
      source2 = 16'h0000;
      source3 = 16'h0000;
      resetRequest = 1'b0;
      resetLock = 1'b0;
      repeat (8) @(negedge sys_clk);
      `CHK("reset status", 64'h0, {statusReg1, statusReg2, statusReg3, latchedAlarms})
      `CHK("reset string", {12{8'h30}}, statusSummaryString)
      `CHK("reset valid", 1'b0, logValid)
      srst = 1'b0;
      setSrc(16'h0000, 16'h0020, 16'h8400);
      setSrc(16'h0000, 16'h0000, 16'h0000);
      repeat (6) setSrc(16'h0000, 16'h0000, 16'($urandom));
      setSrc(16'h0000, 16'h0000, 16'h0000);
      // Event pulse: logged on set and again when the boundary clears it
      expQ.push_back({2'd1, 4'd6, 16'h0200});
      expQ.push_back({2'd1, 4'd6, 16'h0200});
      @(negedge sys_clk);
      source1[6] = 1'b1;
      @(negedge sys_clk);
      source1[6] = 1'b0;
      drain();
      `CHK("event cleared", 1'b0, statusReg1[6])
      setSrc(16'h0003, 16'h0000, 16'h0000);
      setSrc(16'h0002, 16'h0000, 16'h0000);
      `CHK("latched kept", 16'h0043, latchedAlarms)
      resetLock = 1'b1;
      pulseReset();
      `CHK("locked reset", 16'h0043, latchedAlarms)
      resetLock = 1'b0;
      pulseReset();
      `CHK("manual reset", 16'h0002, latchedAlarms)
      setSrc(16'h0000, 16'h0000, 16'h0000);
      `CHK("stamp advanced", 1'b1, lastStamp != 32'h0000_0000)
      end_of_test();
   end
endmodule
